// *** core/scpi_pkg.sv ***
package scpi_pkg;
    localparam int DQ_W = 16;
    localparam int ROW_W = 13;
    localparam int COL_W = 10;
    localparam int BANKS = 4;
    localparam int MEM_DEPTH = 16;
    localparam int MEM_AW = 4;
    localparam int MASK_LAT = 2;
    localparam int AP_BIT = 10;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [12:0] MODE_RST = 13'h0000;
    localparam logic [3:0] FULL_PAGE_LEN = 4'hF;
    // {ras_n, cas_n, we_n}
    typedef enum logic [2:0] {
        SCPI_CMD_CFG = 3'b000,
        SCPI_CMD_REF = 3'b001,
        SCPI_CMD_CLOSE = 3'b010,
        SCPI_CMD_OPEN = 3'b011,
        SCPI_CMD_WRITE = 3'b100,
        SCPI_CMD_READ = 3'b101,
        SCPI_CMD_TERM = 3'b110,
        SCPI_CMD_NOP = 3'b111
    } scpi_cmd_t;
    typedef enum logic [1:0] {
        SCPI_CK_RUN = 2'b00,
        SCPI_CK_HOLD = 2'b01,
        SCPI_CK_PD_IDLE = 2'b10,
        SCPI_CK_PD_ACT = 2'b11
    } scpi_ck_t;
    localparam int DEV_REGS = 1;
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_WDATA = 4'h8;
    localparam logic [3:0] REG_RDATA = 4'hC;
endpackage

// *** core/scpi_if.sv ***
`timescale 1ns/100ps
interface scpi_if;
    logic clk_gate;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank_sel;
    logic [12:0] addr;
    logic low_byte_mask;
    logic high_byte_mask;
    logic [15:0] dq_ctl_o;
    logic dq_ctl_oe;
    logic [15:0] dq_mem_o;
    logic [1:0] dq_mem_oe;
    logic [15:0] dq;
    // resolved bus level seen by both ends
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (dq_mem_oe[i/8]) begin
                dq[i] = dq_mem_o[i];
            end else if (dq_ctl_oe) begin
                dq[i] = dq_ctl_o[i];
            end else begin
                dq[i] = 1'b0;
            end
        end
    end
    modport mem (input clk_gate, cs_n, ras_n, cas_n, we_n, bank_sel, addr,
        low_byte_mask, high_byte_mask, dq, output dq_mem_o, dq_mem_oe);
    modport ctl (output clk_gate, cs_n, ras_n, cas_n, we_n, bank_sel, addr,
        low_byte_mask, high_byte_mask, dq_ctl_o, dq_ctl_oe, input dq);
endinterface

// *** core/scpi_mem.sv ***
`timescale 1ns/100ps
// What this block does
// - all inputs registered on rising ref_clk
// - clock edge advances burst counter, output
// - clock gate low suspends internal clocking
// - gate low: powerdown, active powerdown, hold
// - gate sampled only on rising ref_clk, also while powered down
// - powered down: all other inputs ignored
// - controller may tie clock gate high
// - chip select high masks new commands
// - bursts and masks continue while deselected
// - command from three strobes plus select
// - masked write bytes keep old contents
// - read mask floats outputs two clocks later
// - low mask bits 7:0, high 15:8
// - bank select targets open/read/write/close
// - row-open takes address 12:0 as row
// - column from address bits 9:0
// - address bit 10 selects auto close
// - close: bit 10 all banks, else one
// - config-load captures address as mode opcode
// - controller opens row before read/write
// - burst length 1,2,4,8 or page, terminate
module scpi_mem (
    input wire logic ref_clk,
    input wire logic rst_b,
    scpi_if.mem pins,
    output logic [1:0] ck_mode,
    output logic [3:0] bank_open,
    output logic [12:0] mode_reg
);
    import scpi_pkg::*;

    logic gate_q;
    logic [1:0] mode_q;
    logic [3:0] open_q;
    logic [12:0] row_q [BANKS];
    logic [12:0] mode_q2;
    logic [15:0] mem_q [MEM_DEPTH];
    logic rd_act_q;
    logic wr_act_q;
    logic ap_q;
    logic [1:0] bb_q;
    logic [9:0] col_q;
    logic [3:0] left_q;
    logic [15:0] rdat_q;
    logic rvld_q;
    logic [1:0] m1_q;
    logic [1:0] m2_q;
    logic run;
    logic sel;
    scpi_cmd_t cmd;
    logic burst;
    logic [3:0] blen;
    logic [MEM_AW-1:0] widx;

    assign ck_mode = mode_q;
    assign bank_open = open_q;
    assign mode_reg = mode_q2;
    assign burst = rd_act_q | wr_act_q;
    assign sel = !pins.cs_n;
    assign cmd = scpi_cmd_t'({pins.ras_n, pins.cas_n, pins.we_n});
    // gate sampled at the previous edge; internal clocking stops when gate was low
    assign run = gate_q && mode_q == SCPI_CK_RUN;
    assign widx = col_q[MEM_AW-1:0];

    always_comb begin
        unique case (mode_q2[2:0])
            3'h0: blen = 4'h1;
            3'h1: blen = 4'h2;
            3'h2: blen = 4'h4;
            3'h3: blen = 4'h8;
            BL_FULL: blen = FULL_PAGE_LEN;
            default: blen = 4'h1;
        endcase
    end

    // gate register; in powerdown the gate level is seen only at the next rising edge (no async watch)
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_q <= 1'b1;
        end else begin
            gate_q <= pins.clk_gate;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= SCPI_CK_RUN;
        end else if (!pins.clk_gate) begin
            if (burst) begin
                mode_q <= SCPI_CK_HOLD;
            end else if (open_q == 4'h0) begin
                mode_q <= SCPI_CK_PD_IDLE;
            end else begin
                mode_q <= SCPI_CK_PD_ACT;
            end
        end else begin
            mode_q <= SCPI_CK_RUN;
        end
    end

    // bank and mode state; ignored while suspended or powered down
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            open_q <= 4'h0;
            mode_q2 <= MODE_RST;
            for (int i = 0; i < BANKS; i++) begin
                row_q[i] <= 13'h0000;
            end
        end else if (run && pins.clk_gate) begin
            if (sel && cmd == SCPI_CMD_OPEN) begin
                open_q[pins.bank_sel] <= 1'b1;
                row_q[pins.bank_sel] <= pins.addr;
            end else if (sel && cmd == SCPI_CMD_CLOSE) begin
                if (pins.addr[AP_BIT]) begin
                    open_q <= 4'h0;
                end else begin
                    open_q[pins.bank_sel] <= 1'b0;
                end
            end else if (sel && cmd == SCPI_CMD_CFG) begin
                mode_q2 <= pins.addr;
            end else if (burst && left_q == 4'h1 && ap_q && blen != FULL_PAGE_LEN) begin
                open_q[bb_q] <= 1'b0;
            end
        end
    end

    // burst engine keeps going when deselected
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            ap_q <= 1'b0;
            bb_q <= 2'h0;
            col_q <= 10'h000;
            left_q <= 4'h0;
        end else if (run && pins.clk_gate) begin
            if (sel && (cmd == SCPI_CMD_READ || cmd == SCPI_CMD_WRITE)) begin
                rd_act_q <= cmd == SCPI_CMD_READ;
                wr_act_q <= cmd == SCPI_CMD_WRITE;
                ap_q <= pins.addr[AP_BIT];
                bb_q <= pins.bank_sel;
                col_q <= pins.addr[COL_W-1:0];
                left_q <= blen;
            end else if (sel && cmd == SCPI_CMD_TERM) begin
                rd_act_q <= 1'b0;
                wr_act_q <= 1'b0;
            end else if (burst) begin
                col_q <= col_q + 10'h001;
                // full page wraps until terminated
                if (left_q == 4'h1 && blen != FULL_PAGE_LEN) begin
                    rd_act_q <= 1'b0;
                    wr_act_q <= 1'b0;
                end else if (blen != FULL_PAGE_LEN) begin
                    left_q <= left_q - 4'h1;
                end
            end
        end
    end

    // write path: data captured with the write command and each burst beat
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_q[i] <= 16'h0000;
            end
        end else if (run && pins.clk_gate) begin
            if (sel && cmd == SCPI_CMD_WRITE) begin
                if (!pins.low_byte_mask) begin
                    mem_q[pins.addr[MEM_AW-1:0]][7:0] <= pins.dq[7:0];
                end
                if (!pins.high_byte_mask) begin
                    mem_q[pins.addr[MEM_AW-1:0]][15:8] <= pins.dq[15:8];
                end
            end else if (wr_act_q && left_q != 4'h1 || wr_act_q && blen == FULL_PAGE_LEN) begin
                if (!pins.low_byte_mask) begin
                    mem_q[widx + 4'h1][7:0] <= pins.dq[7:0];
                end
                if (!pins.high_byte_mask) begin
                    mem_q[widx + 4'h1][15:8] <= pins.dq[15:8];
                end
            end
        end
    end

    // read output register plus two-stage mask pipe for the float latency
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdat_q <= 16'h0000;
            rvld_q <= 1'b0;
            m1_q <= 2'h3;
            m2_q <= 2'h3;
        end else if (run && pins.clk_gate) begin
            rdat_q <= mem_q[widx];
            rvld_q <= rd_act_q;
            m1_q <= {pins.high_byte_mask, pins.low_byte_mask};
            m2_q <= m1_q;
        end
    end

    assign pins.dq_mem_o = rdat_q;
    // one assignment for both lanes keeps a single driver on the enable vector
    assign pins.dq_mem_oe = {rvld_q && !m2_q[1],
        rvld_q && !m2_q[0]};
endmodule // scpi_mem

// *** core/scpi_ctl.sv ***
`timescale 1ns/100ps
module scpi_ctl (
    input wire logic ref_clk,
    input wire logic rst_b,
    scpi_if.ctl pins,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import scpi_pkg::*;

    logic [31:0] cmd_q;
    logic [15:0] wdat_q;
    logic [15:0] rdat_q;
    logic busy_q;
    logic [31:0] rd_d;
    logic [31:0] rd_q;
    logic ack_q;

    // one-cycle waitrequest per access, data registered
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata = rd_q;

    always_comb begin
        unique case (avs_address)
            REG_CMD: rd_d = cmd_q;
            REG_STAT: rd_d = {31'h0, busy_q};
            REG_WDATA: rd_d = {16'h0000, wdat_q};
            REG_RDATA: rd_d = {16'h0000, rdat_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            rd_q <= 32'h0000_0000;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
            rd_q <= rd_d;
        end
    end

    // cmd word: [31] gate, [30:28] strobes, [27:26] masks, [25:24] bank, [23] cs_n, [12:0] addr
    // reset shows gate high and no-operation strobes, never a config load
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q <= 32'hF000_0000;
            wdat_q <= 16'h0000;
            busy_q <= 1'b0;
            rdat_q <= 16'h0000;
        end else begin
            busy_q <= 1'b0;
            if (busy_q) begin
                cmd_q[30:28] <= 3'h7;
            end
            // a write lands only at the edge where waitrequest is seen low
            if (avs_write && ack_q && avs_address == REG_CMD) begin
                cmd_q <= avs_writedata;
                busy_q <= 1'b1;
            end
            if (avs_write && ack_q && avs_address == REG_WDATA) begin
                wdat_q <= avs_writedata[15:0];
            end
            rdat_q <= pins.dq;
        end
    end

    assign pins.clk_gate = cmd_q[31];
    assign pins.cs_n = cmd_q[23];
    assign {pins.ras_n, pins.cas_n, pins.we_n} = cmd_q[30:28];
    assign pins.high_byte_mask = cmd_q[27];
    assign pins.low_byte_mask = cmd_q[26];
    assign pins.bank_sel = cmd_q[25:24];
    assign pins.addr = cmd_q[12:0];
    assign pins.dq_ctl_o = wdat_q;
    assign pins.dq_ctl_oe = cmd_q[30:28] == 3'h4;
endmodule // scpi_ctl

// *** test/scpi_monitor.sv ***
`timescale 1ns/100ps
module scpi_monitor
    import scpi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_gate,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bank_sel,
    input wire logic [12:0] addr,
    input wire logic low_byte_mask,
    input wire logic high_byte_mask,
    input wire logic [1:0] dq_mem_oe,
    input wire logic [1:0] ck_mode,
    input wire logic [3:0] bank_open,
    input wire logic [12:0] mode_reg
);
    wire logic [2:0] cmd = {ras_n, cas_n, we_n};
    // a command only counts while the device clock runs
    wire logic take = !cs_n && clk_gate && ck_mode == SCPI_CK_RUN;
    wire logic in_pd = ck_mode == SCPI_CK_PD_IDLE || ck_mode == SCPI_CK_PD_ACT;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    cfg_load_a: assert property (take && cmd == SCPI_CMD_CFG |=> mode_reg == $past(addr))
        else $error("mode register not loaded from address");
    row_open_a: assert property (take && cmd == SCPI_CMD_OPEN |=> bank_open[$past(bank_sel)])
        else $error("row open did not mark its bank");
    close_all_a: assert property (take && cmd == SCPI_CMD_CLOSE && addr[AP_BIT]
        |=> bank_open == 4'h0) else $error("close all left a bank open");
    close_one_a: assert property (take && cmd == SCPI_CMD_CLOSE && !addr[AP_BIT]
        |=> !bank_open[$past(bank_sel)]) else $error("bank close missed");
    low_float_a: assert property (ck_mode == SCPI_CK_RUN && clk_gate && low_byte_mask
        ##1 clk_gate |=> !dq_mem_oe[0]) else $error("low lane driven despite mask");
    high_float_a: assert property (ck_mode == SCPI_CK_RUN && clk_gate && high_byte_mask
        ##1 clk_gate |=> !dq_mem_oe[1]) else $error("high lane driven despite mask");
    desel_hold_a: assert property (cs_n |=> $stable(mode_reg))
        else $error("config load taken while deselected");
    gate_stop_a: assert property (!clk_gate && ck_mode == SCPI_CK_RUN
        |=> ck_mode != SCPI_CK_RUN) else $error("clock kept running with gate low");
    active_pd_a: assert property (!clk_gate && ck_mode == SCPI_CK_RUN && bank_open != 4'h0
        |=> ck_mode != SCPI_CK_PD_IDLE) else $error("idle power down with open row");
    pd_freeze_a: assert property (!clk_gate && in_pd
        |=> $stable(bank_open) && $stable(mode_reg)) else $error("state changed in power down");
    wake_a: assert property (clk_gate && in_pd |=> ck_mode == SCPI_CK_RUN)
        else $error("power down not left on gate rise");
endmodule // scpi_monitor

// *** test/scpi_tb_top.sv ***
`timescale 1ns/100ps
module sdram_command_pin_interface_tb_top;
    import scpi_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] ck_mode;
    logic [3:0] bank_open;
    logic [12:0] mode_reg;
    logic [31:0] q;
    logic desel = 1'b0;
    logic seen_clr = 1'b0;
    logic [15:0] dq_seen = 16'h0000;
    logic [1:0] oe_seen = 2'h0;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    scpi_if pins ();
    scpi_ctl scpi_ctl_i (.ref_clk(ref_clk), .rst_b(rst_b), .pins(pins),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    scpi_mem scpi_mem_i (.ref_clk(ref_clk), .rst_b(rst_b), .pins(pins),
        .ck_mode(ck_mode), .bank_open(bank_open), .mode_reg(mode_reg));
    scpi_monitor scpi_monitor_i (.ref_clk(ref_clk), .rst_b(rst_b), .clk_gate(pins.clk_gate),
        .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
        .bank_sel(pins.bank_sel), .addr(pins.addr), .low_byte_mask(pins.low_byte_mask),
        .high_byte_mask(pins.high_byte_mask), .dq_mem_oe(pins.dq_mem_oe),
        .ck_mode(ck_mode), .bank_open(bank_open), .mode_reg(mode_reg));
    always #4 ref_clk = ~ref_clk;
    // read beats stand one cycle, so they are caught as they pass
    always @(posedge ref_clk) begin
        if (seen_clr) begin
            dq_seen <= 16'h0000;
            oe_seen <= 2'h0;
        end else if (pins.dq_mem_oe != 2'h0) begin
            dq_seen <= pins.dq;
            oe_seen <= pins.dq_mem_oe;
        end
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        // only the cycle counter ends a wait that never finishes
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // command word: gate 31, strobes 30:28, masks 27:26, bank 25:24, deselect 23, address 12:0
    task send(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
        input logic [1:0] m, input logic g);
        bus(1'b1, REG_CMD, {g, c, m, b, desel, 10'h000, a});
        do begin
            bus(1'b0, REG_STAT, 32'h0);
        end while (q[0] !== 1'b0);
        repeat (2) @(posedge ref_clk);
    endtask
    task rd_chk(input logic [12:0] a, input logic [1:0] m, input logic [1:0] oe_exp,
        input logic [15:0] d_exp);
        seen_clr <= 1'b1;
        @(posedge ref_clk);
        seen_clr <= 1'b0;
        send(SCPI_CMD_READ, 2'h0, a, m, 1'b1);
        chk("dq_mem_oe", 32'(oe_seen), 32'(oe_exp));
        chk("dq", 32'(dq_seen), 32'(d_exp));
    endtask
    task t_mode();
        logic [2:0] codes [5] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h0};
        foreach (codes[k]) begin
            send(SCPI_CMD_CFG, 2'h0, {10'h0A5, codes[k]}, 2'h0, 1'b1);
            chk("mode_reg", 32'(mode_reg), 32'({10'h0A5, codes[k]}));
        end
    endtask
    task t_banks();
        send(SCPI_CMD_OPEN, 2'h2, 13'h1ABC, 2'h0, 1'b1);
        chk("bank_open", 32'(bank_open), 32'h4);
        send(SCPI_CMD_OPEN, 2'h1, 13'h0001, 2'h0, 1'b1);
        chk("bank_open", 32'(bank_open), 32'h6);
        send(SCPI_CMD_CLOSE, 2'h2, 13'h1BFF, 2'h0, 1'b1);
        chk("bank_open", 32'(bank_open), 32'h2);
        send(SCPI_CMD_OPEN, 2'h3, 13'h0000, 2'h0, 1'b1);
        send(SCPI_CMD_CLOSE, 2'h0, 13'h0400, 2'h0, 1'b1);
        chk("bank_open", 32'(bank_open), 32'h0);
    endtask
    task t_power();
        send(SCPI_CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b0);
        chk("ck_mode", 32'(ck_mode), 32'(SCPI_CK_PD_IDLE));
        send(SCPI_CMD_OPEN, 2'h0, 13'h0, 2'h0, 1'b0);
        chk("bank_open", 32'(bank_open), 32'h0);
        send(SCPI_CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b1);
        chk("ck_mode", 32'(ck_mode), 32'(SCPI_CK_RUN));
        send(SCPI_CMD_OPEN, 2'h0, 13'h0, 2'h0, 1'b1);
        send(SCPI_CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b0);
        chk("ck_mode", 32'(ck_mode), 32'(SCPI_CK_PD_ACT));
        send(SCPI_CMD_NOP, 2'h0, 13'h0, 2'h0, 1'b1);
        chk("ck_mode", 32'(ck_mode), 32'(SCPI_CK_RUN));
    endtask
    // mask bits: [1] high lane, [0] low lane
    task t_mask();
        bus(1'b1, REG_WDATA, 32'h0000A55A);
        send(SCPI_CMD_WRITE, 2'h0, 13'h0005, 2'h0, 1'b1);
        bus(1'b1, REG_WDATA, 32'h00001234);
        send(SCPI_CMD_WRITE, 2'h0, 13'h0005, 2'h2, 1'b1);
        rd_chk(13'h0005, 2'h0, 2'h3, 16'hA534);
        rd_chk(13'h0005, 2'h2, 2'h1, 16'h0034);
        rd_chk(13'h0005, 2'h3, 2'h0, 16'h0000);
        rd_chk(13'h0005, 2'h1, 2'h2, 16'hA500);
        chk("bank_open", 32'(bank_open), 32'h1);
        rd_chk(13'h0405, 2'h0, 2'h3, 16'hA534);
        chk("bank_open", 32'(bank_open), 32'h0);
    endtask
    task t_select();
        desel = 1'b1;
        send(SCPI_CMD_OPEN, 2'h3, 13'h0000, 2'h0, 1'b1);
        chk("bank_open", 32'(bank_open), 32'h0);
        send(SCPI_CMD_CFG, 2'h0, 13'h0123, 2'h0, 1'b1);
        chk("mode_reg", 32'(mode_reg), 32'h0528);
        desel = 1'b0;
        send(SCPI_CMD_OPEN, 2'h3, 13'h0000, 2'h0, 1'b1);
        chk("bank_open", 32'(bank_open), 32'h8);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        chk("bank_open", 32'(bank_open), 32'h0);
        chk("ck_mode", 32'(ck_mode), 32'(SCPI_CK_RUN));
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", q, 32'h0);
        t_mode();
        t_banks();
        t_power();
        t_mask();
        t_select();
        end_of_test();
    end
endmodule // sdram_command_pin_interface_tb_top
